// ### sdm_col_order.sv
/*
  Column order generator: gives the column of one burst element from the
  start column, the element count, the burst length and the burst type.
  Assumes a purely combinational use by the setup core.
*/
`include "sdm_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module sdm_col_order #(
  parameter int COL_W = `SDM_COL_W
) (
  // Burst description.
  input  wire logic [COL_W-1:0] start_i,
  input  wire logic [COL_W-1:0] count_i,
  input  wire logic [2:0]       bl_code_i,
  input  wire logic             interleave_i,
  input  wire logic [COL_W-1:0] page_mask_i,
  // Resulting column.
  output logic      [COL_W-1:0] col_o
);

  logic [COL_W-1:0] low_m;
  logic             use_xor;

  // Upper bits pick the block, low bits wrap inside it.
  always_comb begin
    unique case (bl_code_i)
      `SDM_BL_2:    low_m = COL_W'(1);
      `SDM_BL_4:    low_m = COL_W'(3);
      `SDM_BL_8:    low_m = COL_W'(7);
      `SDM_BL_PAGE: low_m = page_mask_i;
      default:      low_m = '0;
    endcase
    // Page bursts always count upwards.
    use_xor = interleave_i && (bl_code_i != `SDM_BL_PAGE);
    col_o   = (start_i & ~low_m)
            | ((use_xor ? (start_i ^ count_i)
                        : (start_i + count_i)) & low_m);
  end

endmodule

`default_nettype wire

// ### sdm_ctl_model.sv
/*
  Behavioural memory controller that drives the command pins and the
  write data of the setup core. Assumes the bench calls its tasks.
*/
`timescale 1ns/100ps
`default_nettype none

module sdm_ctl_model import sdm_pkg::*; #(
  parameter int PWR_CYC  = 12500,
  parameter int WAIT_CYC = 3,
  parameter int N_REF    = 3
) (
  // Clock.
  input  wire logic        aclk,
  // Pins towards the core.
  output var  sdm_pins_s   pins,
  output var  logic [15:0] dq
);
  // Clock enable low and deselected at power-up.
  initial begin
    pins = {1'b0, 1'b1, SDM_CMD_NOP, 2'b00, 13'h0000};
    dq   = 16'h5A5A;
  end

  // One command for a cycle, then no-operation; idle data lines toggle.
  task automatic cmd(input sdm_cmd_e c, input logic [12:0] a,
                     input logic [1:0] ba, input logic cs_n);
    @(posedge aclk);
    pins <= {1'b1, cs_n, c, ba, a};
    dq   <= (c == SDM_CMD_WRITE) ? 16'hC350 : ~dq;
    @(posedge aclk);
    pins <= {1'b1, 1'b0, SDM_CMD_NOP, 2'b00, 13'h0000};
    dq   <= (c == SDM_CMD_WRITE) ? 16'hC351 : ~dq;
  endtask

  // Loads the setup word with upper bits zero, then waits quietly.
  task automatic load(input logic [12:0] m, input logic [1:0] ba);
    cmd(SDM_CMD_LOAD_SETUP, {3'b000, m[9:0]}, ba, 1'b0);
    repeat (WAIT_CYC) @(posedge aclk);
  endtask

  // Power-up delay, precharge-all, refresh loops and the first load.
  task automatic init(input logic [12:0] m);
    repeat (PWR_CYC / 2) @(posedge aclk);
    pins <= {1'b1, 1'b0, SDM_CMD_NOP, 2'b00, 13'h0000};
    repeat (PWR_CYC / 2) @(posedge aclk);
    cmd(SDM_CMD_PRECHARGE, 13'h0400, 2'b00, 1'b0);
    repeat (WAIT_CYC) @(posedge aclk);
    for (int i = 0; i < N_REF; i++) begin
      cmd(SDM_CMD_REFRESH, 13'h0000, 2'b00, 1'b0);
      repeat (WAIT_CYC) @(posedge aclk);
    end
    load(m, 2'b00);
  endtask

endmodule

`default_nettype wire

// ### sdm_defs.svh
/*
  Constants of the synchronous DRAM setup block: widths, mode field
  positions, reset values and the register map of the AXI4-Lite slave.
  Assumes it is included by its bare name, once per compilation unit.
*/
`ifndef SDM_DEFS_SVH
`define SDM_DEFS_SVH

// Pin and storage widths.
`define SDM_ADDR_W      13
`define SDM_COL_W       11
`define SDM_DQ_W        16
`define SDM_MODE_W      13
`define SDM_AXI_AW      8

// Mode field positions.
`define SDM_M_BL_LSB    0
`define SDM_M_BL_MSB    2
`define SDM_M_ORDER     3
`define SDM_M_LAT_LSB   4
`define SDM_M_LAT_MSB   6
`define SDM_M_OPM_LSB   7
`define SDM_M_OPM_MSB   8
`define SDM_M_WB        9
`define SDM_A_PRE_ALL   10

// Mode field encodings.
`define SDM_BL_1        3'h0
`define SDM_BL_2        3'h1
`define SDM_BL_4        3'h2
`define SDM_BL_8        3'h3
`define SDM_BL_PAGE     3'h7
`define SDM_LAT_2       3'h2
`define SDM_LAT_3       3'h3
`define SDM_OPM_NORMAL  2'h0

// Page sizes, as column masks, per organisation.
`define SDM_ORG_X4      2'h0
`define SDM_ORG_X8      2'h1
`define SDM_PAGE_X4     11'h7FF
`define SDM_PAGE_X8     11'h3FF
`define SDM_PAGE_X16    11'h1FF

// Reset values and the refresh count limit.
`define SDM_MODE_RST    13'h0000
`define SDM_ORG_RST     2'h2
`define SDM_REF_MAX     4'hF

// Register map and fields.
`define SDM_REG_CTRL    8'h00
`define SDM_REG_STATUS  8'h04
`define SDM_REG_MODE    8'h08
`define SDM_CTRL_ORG_LSB 0
`define SDM_CTRL_ORG_MSB 1
`define SDM_ST_LOADED   0
`define SDM_ST_BURST    1
`define SDM_ST_PRE_ALL  2
`define SDM_ST_REF_LSB  3
`define SDM_ST_REF_MSB  6
`define SDM_ST_RSV      7
`define SDM_ST_OE       8
`define SDM_RESP_OKAY   2'h0
`define SDM_RESP_SLVERR 2'h2

`endif

// ### sdm_mode_core.sv
/*
  Setup and burst core of a four-bank synchronous DRAM: command decode,
  setup register load, column order, read latency and data pin drive,
  plus an AXI4-Lite slave for organisation and status.
  Assumes pins arrive asynchronously and the array answers reads within
  the cycle in which the column is presented.
*/
`include "sdm_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module sdm_mode_core import sdm_pkg::*; #(
  parameter int DQ_W = `SDM_DQ_W
) (
  // Clock and reset.
  input  wire  logic                   aclk,
  input  wire  logic                   aresetn,
  // AXI4-Lite write channels.
  input  wire  logic [`SDM_AXI_AW-1:0] s_axi_awaddr,
  input  wire  logic                   s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire  logic [31:0]            s_axi_wdata,
  input  wire  logic [3:0]             s_axi_wstrb,
  input  wire  logic                   s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire  logic                   s_axi_bready,
  // AXI4-Lite read channels.
  input  wire  logic [`SDM_AXI_AW-1:0] s_axi_araddr,
  input  wire  logic                   s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire  logic                   s_axi_rready,
  // Command, bank and address pins.
  input  wire  sdm_pins_s              pins_i,
  // Data pins.
  input  wire  logic [DQ_W-1:0]        dq_i,
  output logic [DQ_W-1:0]              dq_o,
  output logic                         dq_oe,
  // Array side.
  output logic [`SDM_COL_W-1:0]        arr_col,
  output logic                         arr_rd,
  output logic                         arr_wr,
  output logic [DQ_W-1:0]              arr_wdata,
  input  wire  logic [DQ_W-1:0]        arr_rdata
);

  sdm_state_s q;
  sdm_state_s d;

  sdm_cmd_e              cmd;
  logic                  cmd_ok;
  logic                  is_rw;
  logic                  bank_zero;
  logic                  load_ok;
  logic [2:0]            bl_code;
  logic [2:0]            lat_code;
  logic [1:0]            opm_code;
  logic                  order_il;
  logic                  wr_single_mode;
  logic                  lat3;
  logic                  bl_full;
  logic                  bl_rsv;
  logic [`SDM_COL_W-1:0] page_mask;
  logic [`SDM_COL_W-1:0] col_in;
  logic [`SDM_COL_W-1:0] len_m1;
  logic                  last;
  logic [`SDM_COL_W-1:0] nstart;
  logic [`SDM_COL_W-1:0] ncnt;
  logic [`SDM_COL_W-1:0] next_col;

  // A command counts only with clock enable high and chip select low.
  assign cmd_ok    = q.pin2.cke && !q.pin2.cs_n;
  assign cmd       = cmd_ok ? sdm_cmd_e'({q.pin2.ras_n, q.pin2.cas_n,
                                          q.pin2.we_n})
                            : SDM_CMD_NOP;
  assign is_rw     = (cmd == SDM_CMD_READ) || (cmd == SDM_CMD_WRITE);
  assign bank_zero = !q.pin2.bank_select_high
                  && !q.pin2.bank_select_low;
  assign load_ok   = (cmd == SDM_CMD_LOAD_SETUP) && bank_zero;

  // Fields of the stored setup word.
  assign bl_code        = q.mode[`SDM_M_BL_MSB:`SDM_M_BL_LSB];
  assign order_il       = q.mode[`SDM_M_ORDER];
  assign lat_code       = q.mode[`SDM_M_LAT_MSB:`SDM_M_LAT_LSB];
  assign opm_code       = q.mode[`SDM_M_OPM_MSB:`SDM_M_OPM_LSB];
  assign wr_single_mode = q.mode[`SDM_M_WB];
  assign lat3           = (lat_code == `SDM_LAT_3);
  assign bl_full        = (bl_code == `SDM_BL_PAGE);
  assign bl_rsv         = (bl_code > `SDM_BL_8) && !bl_full;

  // Page size and the column address layout follow the organisation.
  always_comb begin
    unique case (q.org)
      `SDM_ORG_X4: begin
        page_mask = `SDM_PAGE_X4;
        col_in    = {q.pin2.addr[11], q.pin2.addr[9:0]};
      end
      `SDM_ORG_X8: begin
        page_mask = `SDM_PAGE_X8;
        col_in    = {1'b0, q.pin2.addr[9:0]};
      end
      default: begin
        page_mask = `SDM_PAGE_X16;
        col_in    = {2'b00, q.pin2.addr[8:0]};
      end
    endcase
  end

  // Element count minus one for fixed lengths; reserved codes act as one.
  always_comb begin
    unique case (bl_code)
      `SDM_BL_2: len_m1 = `SDM_COL_W'(1);
      `SDM_BL_4: len_m1 = `SDM_COL_W'(3);
      `SDM_BL_8: len_m1 = `SDM_COL_W'(7);
      default:   len_m1 = '0;
    endcase
  end

  // A fixed burst ends on its last element, a page burst never does.
  assign last   = (q.burst != SDM_B_IDLE) && !bl_full
               && (q.single || (q.cnt == len_m1));
  assign nstart = is_rw ? col_in : q.start;
  assign ncnt   = is_rw ? '0 : q.cnt + `SDM_COL_W'(1);

  // Column of the element issued in the next cycle.
  sdm_col_order #(
    .COL_W        (`SDM_COL_W)
  ) u_order (
    .start_i      (nstart),
    .count_i      (ncnt),
    .bl_code_i    (bl_code),
    .interleave_i (order_il),
    .page_mask_i  (page_mask),
    .col_o        (next_col)
  );

  // Next state of the whole core.
  always_comb begin
    logic [31:0] st;
    st = '0;
    d  = q;

    // Pins pass two flip-flops before anything reads them.
    d.pin1 = pins_i;
    d.pin2 = q.pin1;
    d.dq1  = dq_i;
    d.dq2  = q.dq1;

    // Setup load: stores the word, stops any burst, releases the pins.
    if (load_ok) begin
      d.mode     = q.pin2.addr;
      d.loaded   = 1'b1;
      d.rsv_seen = q.rsv_seen
                || (q.pin2.addr[`SDM_M_BL_MSB:`SDM_M_BL_LSB] > `SDM_BL_8
                    && q.pin2.addr[`SDM_M_BL_MSB:`SDM_M_BL_LSB]
                       != `SDM_BL_PAGE)
                || (q.pin2.addr[`SDM_M_LAT_MSB:`SDM_M_LAT_LSB] != `SDM_LAT_2
                    && q.pin2.addr[`SDM_M_LAT_MSB:`SDM_M_LAT_LSB]
                       != `SDM_LAT_3)
                || (q.pin2.addr[`SDM_M_OPM_MSB:`SDM_M_OPM_LSB]
                    != `SDM_OPM_NORMAL);
    end

    // Progress markers of the start-up sequence.
    if ((cmd == SDM_CMD_PRECHARGE) && q.pin2.addr[`SDM_A_PRE_ALL]) begin
      d.pre_all = 1'b1;
    end
    if ((cmd == SDM_CMD_REFRESH) && (q.ref_cnt != `SDM_REF_MAX)) begin
      d.ref_cnt = q.ref_cnt + 4'h1;
    end

    // Burst engine: a new access wins, then stop, then natural end.
    if (cmd == SDM_CMD_READ) begin
      d.burst = SDM_B_READ;
    end else if (cmd == SDM_CMD_WRITE) begin
      d.burst = SDM_B_WRITE;
    end else if (load_ok || (cmd == SDM_CMD_TERMINATE) || last) begin
      d.burst = SDM_B_IDLE;
    end
    if (is_rw) begin
      d.single = (cmd == SDM_CMD_WRITE) && wr_single_mode;
    end
    d.start  = nstart;
    d.cnt    = ncnt;
    d.col    = next_col;
    d.arr_rd = (d.burst == SDM_B_READ);
    d.arr_wr = (d.burst == SDM_B_WRITE);
    d.wdata  = q.dq2;

    // Read data pipeline, flushed by a setup load.
    d.pv[0] = q.arr_rd && !load_ok;
    d.pd[0] = arr_rdata;
    d.pv[1] = q.pv[0] && !load_ok;
    d.pd[1] = q.pd[0];

    // Pins driven one cycle ahead of the data of latency m.
    if (lat3) begin
      d.oe  = d.pv[0] || d.pv[1];
      d.dqo = d.pd[1];
    end else begin
      d.oe  = d.arr_rd || d.pv[0];
      d.dqo = d.pd[0];
    end

    // Write response retires before a new write is taken.
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_got  = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_got  = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end

    // Both halves present: apply the write and answer.
    if (d.aw_got && d.w_got) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = `SDM_RESP_OKAY;
      unique case (d.aw_addr)
        `SDM_REG_CTRL: begin
          if (d.w_strb[0]) begin
            d.org = d.w_data[`SDM_CTRL_ORG_MSB:`SDM_CTRL_ORG_LSB];
          end
        end
        `SDM_REG_STATUS, `SDM_REG_MODE: d.bresp = `SDM_RESP_OKAY;
        default: d.bresp = `SDM_RESP_SLVERR;
      endcase
    end

    // Status word of the core.
    st[`SDM_ST_LOADED]                    = q.loaded;
    st[`SDM_ST_BURST]                     = (q.burst != SDM_B_IDLE);
    st[`SDM_ST_PRE_ALL]                   = q.pre_all;
    st[`SDM_ST_REF_MSB:`SDM_ST_REF_LSB]   = q.ref_cnt;
    st[`SDM_ST_RSV]                       = q.rsv_seen;
    st[`SDM_ST_OE]                        = q.oe;

    // Read channel: one read in flight, answered the next cycle.
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rresp  = `SDM_RESP_OKAY;
      unique case (s_axi_araddr)
        `SDM_REG_CTRL:   d.rdata = {30'h0, q.org};
        `SDM_REG_STATUS: d.rdata = st;
        `SDM_REG_MODE:   d.rdata = {19'h0, q.mode};
        default: begin
          d.rdata = 32'h0000_0000;
          d.rresp = `SDM_RESP_SLVERR;
        end
      endcase
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q      <= '0;
      q.org  <= `SDM_ORG_RST;
      q.mode <= `SDM_MODE_RST;
    end else begin
      q <= d;
    end
  end

  // Bus handshakes and registered outputs.
  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready  = !q.w_got && !q.bvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign dq_o          = q.dqo;
  assign dq_oe         = q.oe;
  assign arr_col       = q.col;
  assign arr_rd        = q.arr_rd;
  assign arr_wr        = q.arr_wr;
  assign arr_wdata     = q.wdata;

endmodule

`default_nettype wire

// ### sdm_mode_core_assertions.sv
/*
  Checker for the setup core: decodes the pins after the two sync stages
  and ties bursts, data drive and loads to the commands that cause them.
  Assumes it is bound to sdm_mode_core and sees only that module's ports.
*/
`include "sdm_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module sdm_mode_core_assertions import sdm_pkg::*; (
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  // Command pins and data drive.
  input wire sdm_pins_s   pins_i,
  input wire logic        dq_oe,
  // Array side.
  input wire logic [10:0] arr_col,
  input wire logic        arr_rd,
  input wire logic        arr_wr
);
  sdm_pins_s   p1_q, p2_q;
  logic [12:0] mode_q;
  logic [2:0]  cmd_c;
  logic [10:0] mask_c;
  logic        live_c, rd_c, wr_c, ld_c, any_c;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Command as the core sees it at edge n.
  assign cmd_c  = {p2_q.ras_n, p2_q.cas_n, p2_q.we_n};
  assign live_c = p2_q.cke && !p2_q.cs_n;
  assign rd_c   = live_c && cmd_c == SDM_CMD_READ;
  assign wr_c   = live_c && cmd_c == SDM_CMD_WRITE;
  assign any_c  = live_c && cmd_c != SDM_CMD_NOP;
  assign ld_c   = live_c && cmd_c == SDM_CMD_LOAD_SETUP &&
                  !p2_q.bank_select_high && !p2_q.bank_select_low;
  assign mask_c = (11'h001 << mode_q[1:0]) - 11'h001;

  // Mirrors the pin synchroniser and the stored setup word.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p1_q   <= '0;
      p2_q   <= '0;
      mode_q <= 13'h0000;
    end else begin
      p1_q <= pins_i;
      p2_q <= p1_q;
      if (ld_c) mode_q <= p2_q.addr;
    end
  end

  // The pins start driving one cycle later at latency three.
  sequence s_late_drive;
    !dq_oe ##1 dq_oe;
  endsequence

  sequence s_one_beat_wr;
    arr_wr ##1 !arr_wr;
  endsequence

  AST_LAT2_DRIVE: assert property (
    rd_c && !dq_oe && !arr_rd && mode_q[6:4] == 3'h2 |=> dq_oe)
    else $error("read at latency two did not drive one cycle later");
  AST_LAT3_DRIVE: assert property (
    rd_c && !dq_oe && !arr_rd && mode_q[6:4] == 3'h3 |=> s_late_drive)
    else $error("read at latency three drove at the wrong edge");
  AST_FIRST_COL: assert property (
    rd_c && mode_q[2] == 1'b0 |=>
      arr_rd && arr_col == $past(p2_q.addr[10:0]))
    else $error("burst did not start at the addressed column");
  AST_SEQ_WRAP: assert property (
    arr_rd && !any_c && !mode_q[3] && mode_q[2:0] inside {3'h1, 3'h2, 3'h3}
    |=> !arr_rd || arr_col == (($past(arr_col) & ~mask_c) |
                               (($past(arr_col) + 11'h001) & mask_c)))
    else $error("sequential burst stepped outside its block");
  AST_SINGLE_READ: assert property (
    rd_c && mode_q[2:0] == 3'h0 |=> arr_rd ##1 !arr_rd)
    else $error("length one read touched more than one column");
  AST_WB_SINGLE: assert property (
    wr_c && mode_q[9] |=> s_one_beat_wr)
    else $error("write with single write mode was not one element");
  AST_LOAD_QUIET: assert property (
    ld_c |=> !dq_oe && !arr_rd && !arr_wr)
    else $error("data pins still driven after a setup load");
  AST_DESELECT: assert property (
    p2_q.cs_n && !dq_oe && !arr_rd && !arr_wr |=> !arr_rd && !arr_wr)
    else $error("deselected cycle started an access");

endmodule

`default_nettype wire

// ### sdm_pkg.sv
/*
  Types of the synchronous DRAM setup block: commands, burst states, the
  command pin group and the packed state of the core.
  Assumes sdm_defs.svh is reachable on the include path.
*/
`include "sdm_defs.svh"

package sdm_pkg;

  // Command code formed from the row, column and write strobes.
  typedef enum logic [2:0] {
    SDM_CMD_LOAD_SETUP = 3'b000,
    SDM_CMD_REFRESH    = 3'b001,
    SDM_CMD_PRECHARGE  = 3'b010,
    SDM_CMD_ACTIVATE   = 3'b011,
    SDM_CMD_WRITE      = 3'b100,
    SDM_CMD_READ       = 3'b101,
    SDM_CMD_TERMINATE  = 3'b110,
    SDM_CMD_NOP        = 3'b111
  } sdm_cmd_e;

  // Burst engine state.
  typedef enum logic [1:0] {
    SDM_B_IDLE  = 2'b00,
    SDM_B_READ  = 2'b01,
    SDM_B_WRITE = 2'b10
  } sdm_burst_e;

  // Command, bank and address pins as sampled together.
  typedef struct packed {
    logic                   cke;
    logic                   cs_n;
    logic                   ras_n;
    logic                   cas_n;
    logic                   we_n;
    logic                   bank_select_high;
    logic                   bank_select_low;
    logic [`SDM_ADDR_W-1:0] addr;
  } sdm_pins_s;

  // Whole state of the core.
  typedef struct packed {
    sdm_pins_s                      pin1;
    sdm_pins_s                      pin2;
    logic [`SDM_DQ_W-1:0]           dq1;
    logic [`SDM_DQ_W-1:0]           dq2;
    logic [`SDM_MODE_W-1:0]         mode;
    logic                           loaded;
    logic                           pre_all;
    logic                           rsv_seen;
    logic [3:0]                     ref_cnt;
    logic [1:0]                     org;
    sdm_burst_e                     burst;
    logic                           single;
    logic [`SDM_COL_W-1:0]          start;
    logic [`SDM_COL_W-1:0]          cnt;
    logic [`SDM_COL_W-1:0]          col;
    logic                           arr_rd;
    logic                           arr_wr;
    logic [`SDM_DQ_W-1:0]           wdata;
    logic [1:0]                     pv;
    logic [1:0][`SDM_DQ_W-1:0]      pd;
    logic                           oe;
    logic [`SDM_DQ_W-1:0]           dqo;
    logic                           aw_got;
    logic                           w_got;
    logic [`SDM_AXI_AW-1:0]         aw_addr;
    logic [31:0]                    w_data;
    logic [3:0]                     w_strb;
    logic                           bvalid;
    logic [1:0]                     bresp;
    logic                           rvalid;
    logic [1:0]                     rresp;
    logic [31:0]                    rdata;
  } sdm_state_s;

endpackage

// ### tb.sv
/*
  Self-checking bench of the setup core: register bus, initialisation,
  burst orders, latencies, deselect, bank bits and write burst mode.
  Assumes the array answers each column with 5'h15 above the column.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sdm_defs.svh"

module tb;
  import sdm_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, dq_oe, arr_rd, arr_wr;
  logic [15:0] dq_i, dq_o, arr_wdata, arr_rdata;
  logic [10:0] arr_col;
  sdm_pins_s   pins_i;
  int          failures = 0;
  int          n_tests = 0;

  sdm_ctl_model ctl_u (.aclk, .pins(pins_i), .dq(dq_i));
  sdm_mode_core dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins_i, .dq_i, .dq_o,
    .dq_oe, .arr_col, .arr_rd, .arr_wr, .arr_wdata, .arr_rdata);

  // Array answers every column with a value made from the column.
  assign arr_rdata = {5'h15, arr_col};

  // Clock of 8 ns period.
  initial forever #4 aclk = ~aclk;

  // Compares one value and counts the result.
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("Checks %0d, failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One register write with its response code.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check("bresp", s_axi_bresp, r);
  endtask

  // One register read with its data and response code.
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check("rdata", s_axi_rdata, d);
    check("rresp", s_axi_rresp, r);
  endtask

  // Reset values, read-only places and unmapped addresses.
  task automatic t_regs();
    axi_rd(`SDM_REG_CTRL, 32'h2, `SDM_RESP_OKAY);
    axi_rd(`SDM_REG_STATUS, 32'h0, `SDM_RESP_OKAY);
    axi_wr(`SDM_REG_CTRL, 32'h1, `SDM_RESP_OKAY);
    axi_rd(`SDM_REG_CTRL, 32'h1, `SDM_RESP_OKAY);
    axi_wr(`SDM_REG_MODE, 32'hFFF, `SDM_RESP_OKAY);
    axi_rd(`SDM_REG_MODE, 32'h0, `SDM_RESP_OKAY);
    axi_wr(8'h0C, 32'h0, `SDM_RESP_SLVERR);
    axi_rd(8'h0C, 32'h0, `SDM_RESP_SLVERR);
    axi_wr(`SDM_REG_CTRL, 32'h2, `SDM_RESP_OKAY);
  endtask

  // Read with element checks at every edge up to the release.
  task automatic rd_chk(input logic [12:0] mw, input logic [10:0] col);
    int m, bl, k;
    logic [10:0] c_exp;
    m  = mw[6:4];
    bl = 1 << mw[1:0];
    ctl_u.cmd(SDM_CMD_READ, {2'b00, col}, 2'b00, 1'b0);
    for (int c = 2; c <= 3 + m + bl; c++) begin
      @(posedge aclk);
      #1;
      check("dq_oe", dq_oe, c >= 1 + m && c < 2 + m + bl);
      if (c >= 2 + m && c < 2 + m + bl) begin
        k = c - 2 - m;
        c_exp = (mw[3] && bl > 1) ? col ^ 11'(k) :
                (col & ~11'(bl - 1)) | (11'(col + k) & 11'(bl - 1));
        check("dq_o", dq_o, {5'h15, c_exp});
      end
    end
  endtask

  // Every fixed length, both orders and both latencies.
  task automatic t_reads();
    logic [12:0] mw [7] = '{13'h022, 13'h03A, 13'h02B, 13'h033,
                            13'h031, 13'h028, 13'h029};
    logic [10:0] cl [7] = '{11'h001, 11'h005, 11'h00B, 11'h1FE,
                            11'h1FF, 11'h017, 11'h0C1};
    for (int i = 0; i < 7; i++) begin
      ctl_u.load(mw[i], 2'b00);
      rd_chk(mw[i], cl[i]);
    end
  endtask

  // Page bursts wrap in the by-eight and by-sixteen pages; a terminate
  // stops the first and a load the second.
  task automatic t_page();
    logic [10:0] pm;
    axi_wr(`SDM_REG_CTRL, 32'h1, `SDM_RESP_OKAY);
    ctl_u.load(13'h027, 2'b00);
    for (int o = 0; o < 2; o++) begin
      pm = o ? 11'h1FF : 11'h3FF;
      ctl_u.cmd(SDM_CMD_READ, {2'b00, pm - 11'h001}, 2'b00, 1'b0);
      repeat (2) @(posedge aclk);
      for (int k = 0; k < 4; k++) begin
        @(posedge aclk);
        #1;
        check("page dq_o", dq_o, {5'h15, 11'(k - 2) & pm});
      end
      if (o == 0) begin
        ctl_u.cmd(SDM_CMD_TERMINATE, 13'h0000, 2'b00, 1'b0);
        repeat (3) @(posedge aclk);
        #1;
        check("term dq_oe", dq_oe, 1'b0);
        axi_wr(`SDM_REG_CTRL, 32'h2, `SDM_RESP_OKAY);
      end
    end
    ctl_u.load(13'h022, 2'b00);
    #1;
    check("load dq_oe", dq_oe, 1'b0);
  endtask

  // Deselected read, loads with bank bits set, write burst mode.
  task automatic t_misc();
    int cnt;
    ctl_u.cmd(SDM_CMD_READ, 13'h0010, 2'b00, 1'b1);
    repeat (8) begin
      @(posedge aclk);
      #1;
      check("deselect", dq_oe | arr_rd, 1'b0);
    end
    for (int b = 1; b < 3; b++) begin
      ctl_u.load(13'h033, b[1:0]);
      axi_rd(`SDM_REG_MODE, 32'h022, `SDM_RESP_OKAY);
    end
    for (int wb = 0; wb < 2; wb++) begin
      cnt = 0;
      ctl_u.load({3'b000, wb[0], 9'h022}, 2'b00);
      ctl_u.cmd(SDM_CMD_WRITE, 13'h0044, 2'b00, 1'b0);
      repeat (12) begin
        @(posedge aclk);
        #1;
        if (arr_wr === 1'b1 && cnt == 0) begin
          check("wr col", arr_col, 11'h044);
          check("wr data", arr_wdata, 16'hC350);
        end
        if (arr_wr === 1'b1) cnt++;
      end
      check("wr count", cnt, wb ? 1 : 4);
    end
    ctl_u.load(13'h0A2, 2'b00);
    axi_rd(`SDM_REG_STATUS, 32'h09D, `SDM_RESP_OKAY);
  endtask

  // Stops a hung run.
  initial begin
    #(8 * 40000);
    failures++;
    finish_test();
  end

  // Reset, initialisation and the scenarios in turn.
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    ctl_u.init(13'h022);
    axi_rd(`SDM_REG_STATUS, 32'h01D, `SDM_RESP_OKAY);
    axi_rd(`SDM_REG_MODE, 32'h022, `SDM_RESP_OKAY);
    t_reads();
    t_page();
    t_misc();
    finish_test();
  end

endmodule

bind sdm_mode_core sdm_mode_core_assertions chk_u (.aclk, .aresetn,
  .pins_i, .dq_oe, .arr_col, .arr_rd, .arr_wr);

`default_nettype wire
